//--- pcsu_defines.svh
`ifndef PCSU_DEFINES_SVH
`define PCSU_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define PCSU_PC_W 12
`define PCSU_PAGE_W 10

// ----------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------
`define PCSU_IDX_PC 4'h2
`define PCSU_IDX_STATUS 4'h3
`define PCSU_IDX_CFG 4'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PCSU_PC_RST 12'h000
`define PCSU_PS_RST 2'h0
`define PCSU_CFG_RST 1'b0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCSU_ST_BUSY 0
`define PCSU_ST_PSLO 5
`define PCSU_ST_PSHI 6
`define PCSU_CFG_EXTRA 0
`define PCSU_CFG_FOUR 1

// ----------------------------------------
// Timing: oscillator clocks per instruction cycle
// ----------------------------------------
`define PCSU_CLKS_SHORT 4'h2
`define PCSU_CLKS_LONG 4'h4

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define PCSU_RESP_OKAY 2'h0
`define PCSU_RESP_SLVERR 2'h2

`endif

//--- pcsu_pkg.sv
package pcsu_pkg;

   typedef enum logic [3:0] {
      PCSU_OP_SEQ = 4'h0,
      PCSU_OP_JUMP = 4'h1,
      PCSU_OP_CALL = 4'h2,
      PCSU_OP_RET = 4'h3,
      PCSU_OP_RETL = 4'h4,
      PCSU_OP_INTERRUPT_POP_BRANCH = 4'h5,
      PCSU_OP_ADD = 4'h6,
      PCSU_OP_LOAD = 4'h7,
      PCSU_OP_WRITE = 4'h8
   } pcsu_op_t;

   typedef enum logic [0:0] {
      PCSU_S_IDLE = 1'b0,
      PCSU_S_RUN = 1'b1
   } pcsu_state_t;

   typedef struct packed {
      pcsu_op_t op;
      logic [9:0] operand;
      logic [7:0] acc;
   } pcsu_instr_t;

endpackage

//--- pcsu_top.sv
// Notes on behaviour
// - Counter and every stack entry are 12 bits wide.
// - Addresses a 4K x 13 program memory split into 1024-word pages.
// - Every reset clears the whole counter to zero.
// - Jump loads the low 10 counter bits from the operand.
// - Call pushes the next address and loads the low 10 bits from the operand.
// - All three return kinds load the counter from the stack top and pop it.
// - Offset sum adds the accumulator to the next address; the carry stops at bit 9.
// - Low load copies the accumulator into bits 7..0, bits 9..8 kept.
// - Other counter writes also keep bits 9..8.
// - Jump, call and counter writes take bits 11..10 from the page selects.
// - Non-branching instructions take one instruction cycle of 2 or 4 clocks.
// - Counter-writing instructions take one or two cycles per the option bit.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pcsu_defines.svh"

module pcsu_top #(
   parameter int STACK_DEPTH = 8,
   parameter int ADDR_W = 8
) (
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire pcsu_pkg::pcsu_instr_t INSTR_IN,
   input wire logic INSTR_VALID_IN,
   output logic INSTR_READY_OUT,
   output logic RETIRE_OUT,
   output logic [`PCSU_PC_W-1:0] FETCH_ADDR_OUT,
   input wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
   input wire logic AXI_AWVALID_IN,
   output logic AXI_AWREADY_OUT,
   input wire logic [31:0] AXI_WDATA_IN,
   input wire logic [3:0] AXI_WSTRB_IN,
   input wire logic AXI_WVALID_IN,
   output logic AXI_WREADY_OUT,
   output logic [1:0] AXI_BRESP_OUT,
   output logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   input wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
   input wire logic AXI_ARVALID_IN,
   output logic AXI_ARREADY_OUT,
   output logic [31:0] AXI_RDATA_OUT,
   output logic [1:0] AXI_RRESP_OUT,
   output logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN
);
   import pcsu_pkg::*;

   localparam int SPW = $clog2(STACK_DEPTH);

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic is_pop(input pcsu_op_t op);
      return op == PCSU_OP_RET || op == PCSU_OP_RETL || op == PCSU_OP_INTERRUPT_POP_BRANCH;
   endfunction

   function automatic logic is_pcw(input pcsu_op_t op);
      return op != PCSU_OP_SEQ;
   endfunction

   // 0 none, 1 counter, 2 status, 3 config
   function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
      logic [1:0] sel;
      sel = 2'h0;
      if (addr[1:0] == 2'h0 && addr[ADDR_W-1:6] == '0) begin
         if (addr[5:2] == `PCSU_IDX_PC) sel = 2'h1;
         if (addr[5:2] == `PCSU_IDX_STATUS) sel = 2'h2;
         if (addr[5:2] == `PCSU_IDX_CFG) sel = 2'h3;
      end
      return sel;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [`PCSU_PC_W-1:0] pc_r;
   logic [`PCSU_PC_W-1:0] tgt_r;
   logic [`PCSU_PC_W-1:0] stk_r [STACK_DEPTH];
   logic [SPW-1:0] sp_r;
   logic [2:0] cnt_r;
   pcsu_state_t state_r;
   logic ready_r;
   logic retire_r;
   logic [1:0] ps_r;
   logic extra_r;
   logic four_r;

   // ----------------------------------------
   // Sequencing datapath
   // ----------------------------------------
   pcsu_op_t op_w;
   wire take_w = INSTR_VALID_IN && ready_r;
   wire finishing_w = state_r == PCSU_S_RUN && cnt_r == 3'h0;
   // A new instruction may be taken in the finishing cycle, so it must see
   // the target that is about to land rather than the stale counter.
   wire [`PCSU_PC_W-1:0] pc_eff_w = finishing_w ? tgt_r : pc_r;
   wire [`PCSU_PC_W-1:0] base_w = pc_eff_w + 12'h001;
   wire [`PCSU_PC_W-1:0] sum_w = base_w + {4'h0, INSTR_IN.acc};
   wire [SPW-1:0] sp_dec_w = sp_r - SPW'(1);
   wire [`PCSU_PC_W-1:0] top_w = stk_r[sp_dec_w];
   wire push_w = take_w && op_w == PCSU_OP_CALL;
   wire pop_w = take_w && is_pop(op_w);
   wire [`PCSU_PC_W-1:0] tgt_nxt;
   wire [3:0] clks_w;
   wire [3:0] total_w;
   wire [2:0] cnt_nxt;
   pcsu_state_t state_nxt;

   assign op_w = INSTR_IN.op;
   assign tgt_nxt =
      (op_w == PCSU_OP_JUMP || op_w == PCSU_OP_CALL) ?
         {ps_r, INSTR_IN.operand} :
      is_pop(op_w) ? top_w :
      (op_w == PCSU_OP_ADD) ? {ps_r, sum_w[9:0]} :
      (op_w == PCSU_OP_LOAD || op_w == PCSU_OP_WRITE) ?
         {ps_r, base_w[9:8], INSTR_IN.acc} :
      base_w;

   assign clks_w = four_r ? `PCSU_CLKS_LONG : `PCSU_CLKS_SHORT;
   assign total_w = (is_pcw(op_w) && extra_r) ? 4'(clks_w << 1) : clks_w;
   assign cnt_nxt = take_w ? 3'(total_w - 4'h1) :
                    (state_r == PCSU_S_RUN && cnt_r != 3'h0) ? 3'(cnt_r - 3'h1) : 3'h0;
   assign state_nxt = take_w ? PCSU_S_RUN : finishing_w ? PCSU_S_IDLE : state_r;

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_r <= PCSU_S_IDLE;
         cnt_r <= 3'h0;
         ready_r <= 1'b1;
         retire_r <= 1'b0;
         tgt_r <= `PCSU_PC_RST;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         ready_r <= state_nxt == PCSU_S_IDLE || cnt_nxt == 3'h0;
         retire_r <= finishing_w;
         tgt_r <= take_w ? tgt_nxt : tgt_r;
      end
   end

   // ----------------------------------------
   // Hardware stack, circular on overflow and underflow
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         sp_r <= '0;
      end else if (push_w) begin
         sp_r <= SPW'(sp_r + SPW'(1));
      end else if (pop_w) begin
         sp_r <= sp_dec_w;
      end
   end

   genvar g;
   generate
      for (g = 0; g < STACK_DEPTH; g++) begin : g_stk
         always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
               stk_r[g] <= `PCSU_PC_RST;
            end else if (push_w && sp_r == SPW'(g)) begin
               stk_r[g] <= base_w;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Register bus slave
   // ----------------------------------------
   logic aw_have_r;
   logic w_have_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   wire aw_take_w = AXI_AWVALID_IN && !aw_have_r;
   wire w_take_w = AXI_WVALID_IN && !w_have_r;
   // Held off for the finishing cycle so a bus write never races the engine.
   wire do_wr_w = aw_have_r && w_have_r && !bvalid_r && !finishing_w;
   wire [1:0] wsel_w = reg_sel(awaddr_r);
   wire [1:0] rsel_w = reg_sel(AXI_ARADDR_IN);
   wire ar_take_w = AXI_ARVALID_IN && arready_r;
   wire [31:0] rd_status_w = (32'(state_r == PCSU_S_RUN) << `PCSU_ST_BUSY) |
                             (32'(ps_r[0]) << `PCSU_ST_PSLO) |
                             (32'(ps_r[1]) << `PCSU_ST_PSHI);
   wire [31:0] rd_cfg_w = (32'(extra_r) << `PCSU_CFG_EXTRA) |
                          (32'(four_r) << `PCSU_CFG_FOUR);
   wire [31:0] rd_val_w = (rsel_w == 2'h1) ? {20'h00000, pc_r} :
                          (rsel_w == 2'h2) ? rd_status_w :
                          (rsel_w == 2'h3) ? rd_cfg_w : 32'h00000000;

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `PCSU_RESP_OKAY;
      end else begin
         if (aw_take_w) begin
            aw_have_r <= 1'b1;
            awaddr_r <= AXI_AWADDR_IN;
         end else if (do_wr_w) begin
            aw_have_r <= 1'b0;
         end
         if (w_take_w) begin
            w_have_r <= 1'b1;
            wdata_r <= AXI_WDATA_IN;
            wstrb_r <= AXI_WSTRB_IN;
         end else if (do_wr_w) begin
            w_have_r <= 1'b0;
         end
         if (do_wr_w) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wsel_w == 2'h0) ? `PCSU_RESP_SLVERR : `PCSU_RESP_OKAY;
         end else if (AXI_BREADY_IN) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `PCSU_RESP_OKAY;
      end else if (ar_take_w) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_val_w;
         rresp_r <= (rsel_w == 2'h0) ? `PCSU_RESP_SLVERR : `PCSU_RESP_OKAY;
      end else if (rvalid_r && AXI_RREADY_IN) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Software-visible registers
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         pc_r <= `PCSU_PC_RST;
         ps_r <= `PCSU_PS_RST;
         extra_r <= `PCSU_CFG_RST;
         four_r <= `PCSU_CFG_RST;
      end else if (finishing_w) begin
         pc_r <= tgt_r;
      end else if (do_wr_w) begin
         if (wsel_w == 2'h1 && wstrb_r[0]) pc_r[7:0] <= wdata_r[7:0];
         if (wsel_w == 2'h1 && wstrb_r[1]) pc_r[11:8] <= wdata_r[11:8];
         if (wsel_w == 2'h2 && wstrb_r[0]) begin
            ps_r <= {wdata_r[`PCSU_ST_PSHI], wdata_r[`PCSU_ST_PSLO]};
         end
         if (wsel_w == 2'h3 && wstrb_r[0]) begin
            extra_r <= wdata_r[`PCSU_CFG_EXTRA];
            four_r <= wdata_r[`PCSU_CFG_FOUR];
         end
      end
   end

   assign INSTR_READY_OUT = ready_r;
   assign RETIRE_OUT = retire_r;
   assign FETCH_ADDR_OUT = pc_r;
   assign AXI_AWREADY_OUT = !aw_have_r;
   assign AXI_WREADY_OUT = !w_have_r;
   assign AXI_BVALID_OUT = bvalid_r;
   assign AXI_BRESP_OUT = bresp_r;
   assign AXI_ARREADY_OUT = arready_r;
   assign AXI_RVALID_OUT = rvalid_r;
   assign AXI_RDATA_OUT = rdata_r;
   assign AXI_RRESP_OUT = rresp_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   sequence s_done_after_1;
      ##1 !retire_r ##1 retire_r;
   endsequence
   sequence s_done_after_3;
      ##1 !retire_r [*3] ##1 retire_r;
   endsequence
   sequence s_done_after_7;
      ##1 !retire_r [*7] ##1 retire_r;
   endsequence

   jump_target_a: assert property (
      take_w && op_w == PCSU_OP_JUMP |=>
         tgt_r == {$past(ps_r), $past(INSTR_IN.operand)})
      else $error("jump target not taken from page select and operand");
   call_push_a: assert property (
      take_w && op_w == PCSU_OP_CALL |=>
         stk_r[$past(sp_r)] == $past(base_w) && tgt_r[9:0] == $past(INSTR_IN.operand))
      else $error("call did not push next address");
   return_pop_a: assert property (
      pop_w |=> tgt_r == $past(top_w) && sp_r == $past(sp_dec_w))
      else $error("return did not pop stack top");
   offset_sum_a: assert property (
      take_w && op_w == PCSU_OP_ADD |=>
         tgt_r[9:0] == 10'($past(base_w) + {4'h0, $past(INSTR_IN.acc)}))
      else $error("offset sum wrong");
   low_load_a: assert property (
      take_w && op_w == PCSU_OP_LOAD |=>
         tgt_r[9:0] == {$past(base_w[9:8]), $past(INSTR_IN.acc)})
      else $error("low load changed bits 9..8");
   write_keep_a: assert property (
      take_w && op_w == PCSU_OP_WRITE |=>
         tgt_r[11:8] == {$past(ps_r), $past(base_w[9:8])})
      else $error("counter write changed bits 9..8");
   single_cycle_a: assert property (
      take_w && !is_pcw(op_w) && !four_r |=> s_done_after_1)
      else $error("plain instruction not one short cycle");
   single_long_a: assert property (
      take_w && !is_pcw(op_w) && four_r |=> s_done_after_3)
      else $error("plain instruction not one long cycle");
   extra_cycle_a: assert property (
      take_w && is_pcw(op_w) && extra_r && four_r |=> s_done_after_7)
      else $error("branch did not take two long cycles");
   stack_wrap_a: assert property (
      push_w && sp_r == SPW'(STACK_DEPTH - 1) |=> sp_r == '0)
      else $error("stack pointer did not wrap");
   retire_load_a: assert property (
      finishing_w |=> pc_r == $past(tgt_r) && retire_r)
      else $error("counter not loaded at retire");

endmodule

//--- pcsu_imem_model.sv
`timescale 1ns/1ps
module pcsu_imem_model (
   input wire logic clk_in,
   input wire logic instr_ready_in,
   output pcsu_pkg::pcsu_instr_t instr_out,
   output logic instr_valid_out
);
   import pcsu_pkg::*;

   initial begin
      instr_out = '0;
      instr_valid_out = 1'b0;
   end
   // Offers one word after an optional stall and holds it until taken
   task automatic offer(input pcsu_instr_t ins, input int gap);
      repeat (gap) @(posedge clk_in);
      @(posedge clk_in);
      instr_out <= ins;
      instr_valid_out <= 1'b1;
      do @(posedge clk_in); while (instr_ready_in !== 1'b1);
      instr_valid_out <= 1'b0;
      // Scrambled after release so a stale operand can never pass as live
      instr_out <= pcsu_instr_t'(~ins);
   endtask
endmodule

//--- test_program_counter_stack_unit.sv
`timescale 1ns/1ps
`include "pcsu_defines.svh"
module test_program_counter_stack_unit;
   import pcsu_pkg::*;
   localparam logic [7:0] A_PC = {2'h0, `PCSU_IDX_PC, 2'h0};
   localparam logic [7:0] A_ST = {2'h0, `PCSU_IDX_STATUS, 2'h0};
   localparam logic [7:0] A_CFG = {2'h0, `PCSU_IDX_CFG, 2'h0};
   localparam logic [1:0] OK = `PCSU_RESP_OKAY;
   localparam logic [1:0] ERR = `PCSU_RESP_SLVERR;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   pcsu_instr_t instr;
   logic instr_valid, instr_ready, retire;
   logic [`PCSU_PC_W-1:0] fetch_addr;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int fails = 0;
   int tests_run = 0;
   int gap = 0;
   int clks;

   always #2 clk = ~clk;

   pcsu_top #(.STACK_DEPTH(2), .ADDR_W(8)) i_pcsu_top (
      .CLK_IN(clk), .RESET_N_IN(rst_n), .INSTR_IN(instr), .INSTR_VALID_IN(instr_valid),
      .INSTR_READY_OUT(instr_ready), .RETIRE_OUT(retire), .FETCH_ADDR_OUT(fetch_addr),
      .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
      .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid),
      .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid),
      .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
      .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
      .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready));

   pcsu_imem_model i_pcsu_imem_model (
      .clk_in(clk), .instr_ready_in(instr_ready), .instr_out(instr),
      .instr_valid_out(instr_valid));

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_check(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp_resp);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      check({30'h0, bresp}, {30'h0, exp_resp});
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp,
                           input logic [1:0] exp_resp);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      rready <= 1'b0;
      check(rdata, exp);
      check({30'h0, rresp}, {30'h0, exp_resp});
   endtask

   // Runs one instruction and checks its length and the counter it leaves
   task automatic exec(input pcsu_op_t op, input logic [9:0] opnd, input logic [7:0] acc,
                       input logic [11:0] exp_pc, input int exp_t);
      pcsu_instr_t ins;
      int n;
      ins.op = op;
      ins.operand = opnd;
      ins.acc = acc;
      i_pcsu_imem_model.offer(ins, gap);
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n == 1) check(32'(instr_ready), 32'h0);
      end while (retire !== 1'b1 && n < 40);
      // First negedge already follows the take edge, so n runs one past the edge count
      check(32'(n - 1), 32'(exp_t));
      check(32'(instr_ready), 32'h1);
      check({20'h0, fetch_addr}, {20'h0, exp_pc});
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd_check(A_PC, 32'h0, OK);
      rd_check(A_ST, 32'h0, OK);
      rd_check(A_CFG, 32'h0, OK);
      rd_check(8'h40, 32'h0, ERR);
      wr_check(8'h44, 32'h5, 4'hF, ERR);
      $display("test reset_and_map done");
      wr_check(A_ST, 32'hFF, 4'hF, OK);
      rd_check(A_ST, 32'h60, OK);
      wr_check(A_ST, 32'h40, 4'hF, OK);
      wr_check(A_PC, 32'h123, 4'hF, OK);
      wr_check(A_PC, 32'hFFF, 4'h2, OK);
      rd_check(A_PC, 32'hF23, OK);
      $display("test registers done");
      exec(PCSU_OP_SEQ, 10'h000, 8'h00, 12'hF24, 2);
      exec(PCSU_OP_JUMP, 10'h155, 8'h00, 12'h955, 2);
      exec(PCSU_OP_CALL, 10'h0AA, 8'h00, 12'h8AA, 2);
      exec(PCSU_OP_RET, 10'h000, 8'h00, 12'h956, 2);
      exec(PCSU_OP_LOAD, 10'h000, 8'h34, 12'h934, 2);
      exec(PCSU_OP_WRITE, 10'h000, 8'hC8, 12'h9C8, 2);
      exec(PCSU_OP_ADD, 10'h000, 8'hFF, 12'hAC8, 2);
      $display("test opcodes done");
      wr_check(A_ST, 32'h20, 4'hF, OK);
      gap = 3;
      for (int k = 1; k < 4; k++) begin
         wr_check(A_CFG, 32'(k), 4'hF, OK);
         clks = k[1] ? 4 : 2;
         exec(PCSU_OP_JUMP, 10'h3FF, 8'h00, 12'h7FF, k[0] ? 2 * clks : clks);
         exec(PCSU_OP_SEQ, 10'h000, 8'h00, 12'h800, clks);
      end
      gap = 0;
      wr_check(A_CFG, 32'h0, 4'hF, OK);
      $display("test cycle_timing done");
      exec(PCSU_OP_CALL, 10'h001, 8'h00, 12'h401, 2);
      exec(PCSU_OP_CALL, 10'h002, 8'h00, 12'h402, 2);
      exec(PCSU_OP_CALL, 10'h010, 8'h00, 12'h410, 2);
      exec(PCSU_OP_RETL, 10'h000, 8'h00, 12'h403, 2);
      exec(PCSU_OP_INTERRUPT_POP_BRANCH, 10'h000, 8'h00, 12'h402, 2);
      exec(PCSU_OP_RET, 10'h000, 8'h00, 12'h403, 2);
      $display("test stack_wrap done");
      @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      check({20'h0, fetch_addr}, 32'h0);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_check(A_PC, 32'h0, OK);
      $display("test second_reset done");
      tally_and_finish();
   end

   // Whole run is well under a thousand cycles; this only cuts a hang short
   initial begin
      #(20000 * 4);
      fails++;
      tally_and_finish();
   end
endmodule
